// [port_pin_alternate_override.sv]
// port A pin control with alternate-function overrides behind an APB slave
//
// Design decisions made here: the APB slave port and the address map.
`include "port_override_params.svh"
module port_pin_alternate_override (
    input wire logic pclk,
    input wire logic presetn,
    input wire port_override_pkg::apb_addr_t paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire port_override_pkg::word_t pwdata,
    output port_override_pkg::word_t prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep,
    input wire port_override_pkg::pin_vec_t ext_irq_enable,
    input wire port_override_pkg::pin_vec_t port_toggle_override_enable,
    input wire port_override_pkg::pin_vec_t pad_in,
    output port_override_pkg::pin_vec_t pad_out,
    output port_override_pkg::pin_vec_t pad_oe,
    output port_override_pkg::pin_vec_t pullup_enable,
    output port_override_pkg::pin_vec_t pin_input_to_function,
    output port_override_pkg::pin_vec_t analog_pad_path
);
    import port_override_pkg::*;

    pin_vec_t direction_bit;
    pin_vec_t output_value_bit;
    logic global_pullup_disable;
    pin_vec_t pin_input_disable;
    pin_vec_t pin_change_mask;
    logic pin_change_group_enable;
    channel_sel_t voltage_converter_channel_select;
    pin_vec_t pin_sample_bit;
    pin_vec_t next_output_value_bit;
    pin_vec_t toggle_mask;
    pin_vec_t sw_toggle;
    word_t read_word;
    logic setup;
    logic access;
    logic wr;
    logic hit_dir;
    logic hit_out;
    logic hit_pin;
    logic hit_ctrl;
    logic hit_acfg;
    logic mapped;

    // analog path taps the pad with no gate in between
    assign analog_pad_path = pad_in;

    // one wait state: pready rises for the cycle after setup only
    assign setup = psel & ~penable;
    assign access = psel & penable & pready;
    assign wr = access & pwrite;
    assign hit_dir = paddr == `ADDR_DIR;
    assign hit_out = paddr == `ADDR_OUT;
    assign hit_pin = paddr == `ADDR_PIN;
    assign hit_ctrl = paddr == `ADDR_CTRL;
    assign hit_acfg = paddr == `ADDR_ACFG;
    assign mapped = hit_dir | hit_out | hit_pin | hit_ctrl | hit_acfg;

    assign read_word = hit_dir ? {30'h0, direction_bit}
        : hit_out ? {30'h0, output_value_bit}
        : hit_pin ? {30'h0, pin_sample_bit}
        : hit_ctrl ? {31'h0, global_pullup_disable}
        : hit_acfg ? {24'h0, voltage_converter_channel_select,
            pin_change_group_enable, pin_change_mask, pin_input_disable}
        : 32'h0;

    // both toggle sources in one cycle invert the bit once, not twice
    assign sw_toggle = (wr & hit_pin) ? pwdata[1:0] : 2'h0;
    assign toggle_mask = sw_toggle | port_toggle_override_enable;
    assign next_output_value_bit =
        ((wr & hit_out) ? pwdata[1:0] : output_value_bit) ^ toggle_mask;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            if (setup) begin
                prdata <= pwrite ? 32'h0 : read_word;
            end
        end
    end

    // reset leaves every pin a Hi-Z input with no override in force
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            direction_bit <= `DIR_RST;
            output_value_bit <= `OUT_RST;
        end else begin
            output_value_bit <= next_output_value_bit;
            if (wr & hit_dir) begin
                direction_bit <= pwdata[1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_pullup_disable <= `PUD_RST;
            pin_input_disable <= `DID_RST;
            pin_change_mask <= `PCM_RST;
            pin_change_group_enable <= `PCE_RST;
            voltage_converter_channel_select <= `SEL_RST;
        end else if (wr & hit_ctrl) begin
            global_pullup_disable <= pwdata[`CTRL_PUD_BIT];
        end else if (wr & hit_acfg) begin
            pin_input_disable <= pwdata[`ACFG_DID_LSB +: 2];
            pin_change_mask <= pwdata[`ACFG_PCM_LSB +: 2];
            pin_change_group_enable <= pwdata[`ACFG_PCE_BIT];
            voltage_converter_channel_select <= pwdata[`ACFG_SEL_LSB +: 3];
        end
    end

    genvar i;
    generate
        for (i = 0; i < `PORT_PINS; i = i + 1) begin : g_pin
            logic gnd_sel;
            logic ie_ov_en;
            logic ie_ov_val;
            // channel code picks the pin that becomes signal ground
            assign gnd_sel = voltage_converter_channel_select ==
                ((i == 1) ? `SEL_PIN1_GND : `SEL_PIN0_GND);
            assign ie_ov_en = pin_input_disable[i]
                | (pin_change_mask[i] & pin_change_group_enable);
            assign ie_ov_val = ~pin_input_disable[i];

            // signal ground: driver on, value low; pull-up never overridden
            pin_override_cell u_cell (
                .pclk(pclk),
                .presetn(presetn),
                .sleep(sleep),
                .ext_irq_enable(ext_irq_enable[i]),
                .direction_bit(direction_bit[i]),
                .output_value_bit(output_value_bit[i]),
                .global_pullup_disable(global_pullup_disable),
                .pullup_override_enable(1'b0),
                .pullup_override_value(1'b0),
                .direction_override_enable(gnd_sel),
                .direction_override_value(1'b1),
                .port_value_override_enable(gnd_sel),
                .port_value_override_value(1'b0),
                .input_enable_override_enable(ie_ov_en),
                .input_enable_override_value(ie_ov_val),
                .pad_in(pad_in[i]),
                .pad_out(pad_out[i]),
                .pad_oe(pad_oe[i]),
                .pullup_enable(pullup_enable[i]),
                .pin_input_to_function(pin_input_to_function[i]),
                .pin_sample_bit(pin_sample_bit[i])
            );
        end
    endgenerate

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence apb_setup;
        psel && !penable;
    endsequence
    chk_apb_one_wait: assert property (
        apb_setup |=> pready ##1 !pready)
        else $error("apb answer not one wait state");
    chk_sw_toggle_out: assert property (
        wr && hit_pin && port_toggle_override_enable == 2'h0
        |=> output_value_bit ==
        ($past(output_value_bit) ^ $past(pwdata[1:0])))
        else $error("pin write did not toggle output bit");
    chk_periph_toggle: assert property (
        port_toggle_override_enable != 2'h0 && !(wr && (hit_pin || hit_out))
        |=> output_value_bit == ($past(output_value_bit)
        ^ $past(port_toggle_override_enable)))
        else $error("toggle override not applied");
    chk_pin1_ground: assert property (
        voltage_converter_channel_select == `SEL_PIN1_GND
        |-> pad_oe[1] && !pad_out[1])
        else $error("pin 1 not signal ground");
    chk_pin0_ground: assert property (
        voltage_converter_channel_select == `SEL_PIN0_GND
        |-> pad_oe[0] && !pad_out[0])
        else $error("pin 0 not signal ground");
    chk_disabled_input: assert property (
        pin_input_disable[0] |-> !pin_input_to_function[0])
        else $error("disabled input still passes");
    chk_global_pud: assert property (
        global_pullup_disable |-> pullup_enable == 2'h0)
        else $error("pull-up on with global disable");
    chk_direction_plain: assert property (
        voltage_converter_channel_select != `SEL_PIN1_GND
        |-> pad_oe[1] == direction_bit[1])
        else $error("driver does not follow direction bit");
endmodule : port_pin_alternate_override

// [port_override_params.svh]
// constants for the port pin override block
`ifndef PORT_OVERRIDE_PARAMS_SVH
`define PORT_OVERRIDE_PARAMS_SVH

`define PORT_PINS 2
`define ADDR_W 12
`define ADDR_DIR 12'h000
`define ADDR_OUT 12'h004
`define ADDR_PIN 12'h008
`define ADDR_CTRL 12'h00C
`define ADDR_ACFG 12'h010
`define CTRL_PUD_BIT 0
`define ACFG_DID_LSB 0
`define ACFG_PCM_LSB 2
`define ACFG_PCE_BIT 4
`define ACFG_SEL_LSB 5
`define SEL_W 3
`define SEL_PIN1_GND 3'h1
`define SEL_PIN0_GND 3'h2
`define DIR_RST 2'h0
`define OUT_RST 2'h0
`define PUD_RST 1'h0
`define DID_RST 2'h0
`define PCM_RST 2'h0
`define PCE_RST 1'h0
`define SEL_RST 3'h0

`endif

// [port_override_pkg.sv]
// types shared by the port pin override block
package port_override_pkg;
`include "port_override_params.svh"
    typedef logic [`PORT_PINS-1:0] pin_vec_t;
    typedef logic [`SEL_W-1:0] channel_sel_t;
    typedef logic [`ADDR_W-1:0] apb_addr_t;
    typedef logic [31:0] word_t;
endpackage : port_override_pkg

// [pin_override_cell.sv]
// one pad: override selection, sleep clamp and input synchroniser
module pin_override_cell (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sleep,
    input wire logic ext_irq_enable,
    input wire logic direction_bit,
    input wire logic output_value_bit,
    input wire logic global_pullup_disable,
    input wire logic pullup_override_enable,
    input wire logic pullup_override_value,
    input wire logic direction_override_enable,
    input wire logic direction_override_value,
    input wire logic port_value_override_enable,
    input wire logic port_value_override_value,
    input wire logic input_enable_override_enable,
    input wire logic input_enable_override_value,
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe,
    output logic pullup_enable,
    output logic pin_input_to_function,
    output logic pin_sample_bit
);
    logic pu_plain;
    logic pu_pick;
    logic drive_en;
    logic sleep_clamp;
    logic input_en;
    logic sync_latch;

    // pad path is pure logic so overrides reach the pad in the same cycle
    assign pu_plain = ~direction_bit & output_value_bit
        & ~global_pullup_disable;
    assign pu_pick = pullup_override_enable ? pullup_override_value
        : pu_plain;
    // reset removes pull-ups and drivers even with no clock running
    assign pullup_enable = presetn & pu_pick;
    assign drive_en = direction_override_enable ? direction_override_value
        : direction_bit;
    assign pad_oe = presetn & drive_en;
    assign pad_out = drive_en & (port_value_override_enable
        ? port_value_override_value : output_value_bit);
    assign sleep_clamp = sleep & ~ext_irq_enable;
    assign input_en = input_enable_override_enable
        ? input_enable_override_value : ~sleep_clamp;
    // clamp to ground ahead of the trigger; release on wake can raise
    // an edge on a high pin, which interrupt logic will then see
    assign pin_input_to_function = pad_in & input_en;

    // latch closes on the falling edge, register takes it on the next rise
    always_ff @(negedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_latch <= 1'b0;
        end else begin
            sync_latch <= pin_input_to_function;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sample_bit <= 1'b0;
        end else begin
            pin_sample_bit <= sync_latch;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence input_held_high;
        pin_input_to_function [*2];
    endsequence
    chk_sample_follows_input: assert property (
        input_held_high |=> pin_sample_bit)
        else $error("sample bit missed a steady high input");
    chk_pullup_override_value: assert property (
        pullup_override_enable |-> pullup_enable == pullup_override_value)
        else $error("pull-up ignores its override");
    chk_pullup_plain_path: assert property (
        !pullup_override_enable |-> pullup_enable ==
        (!direction_bit && output_value_bit && !global_pullup_disable))
        else $error("pull-up wrong without override");
    chk_driver_override: assert property (
        direction_override_enable |-> pad_oe == direction_override_value)
        else $error("driver ignores direction override");
    chk_driven_value: assert property (
        pad_oe && port_value_override_enable
        |-> pad_out == port_value_override_value)
        else $error("pad value ignores value override");
    chk_sleep_clamp_low: assert property (
        sleep && !ext_irq_enable && !input_enable_override_enable
        |-> !pin_input_to_function)
        else $error("sleep clamp not applied");
    chk_irq_pin_unclamped: assert property (
        ext_irq_enable && !input_enable_override_enable
        |-> pin_input_to_function == pad_in)
        else $error("interrupt pin was clamped");
    chk_input_override: assert property (
        input_enable_override_enable && !input_enable_override_value
        |-> !pin_input_to_function)
        else $error("input override not honoured");
endmodule : pin_override_cell

// [pad_far_side.sv]
// far-side pad model: external drivers, pull-up and a floating level
`include "port_override_params.svh"
module pad_far_side (
    input wire logic pclk,
    input wire port_override_pkg::pin_vec_t pad_out,
    input wire port_override_pkg::pin_vec_t pad_oe,
    input wire port_override_pkg::pin_vec_t pullup_enable,
    input wire port_override_pkg::pin_vec_t ext_drive_en,
    input wire port_override_pkg::pin_vec_t ext_level,
    output port_override_pkg::pin_vec_t pad_in
);
    timeunit 1ns;
    timeprecision 1ns;
    import port_override_pkg::*;

    // undriven pad flips every cycle so a settled unknown never passes
    pin_vec_t wobble = '0;

    always @(posedge pclk) begin
        wobble <= ~wobble;
    end

    always_comb begin
        for (int i = 0; i < `PORT_PINS; i++) begin
            if (pad_oe[i]) begin
                pad_in[i] = pad_out[i];
            end else if (ext_drive_en[i]) begin
                pad_in[i] = ext_level[i];
            end else if (pullup_enable[i]) begin
                pad_in[i] = 1'b1;
            end else begin
                pad_in[i] = wobble[i];
            end
        end
    end
endmodule : pad_far_side

// [port_pin_alternate_override_test.sv]
// self-checking bench for the port pin override block
`include "port_override_params.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
    num_errors++; $display("[ERR] %0t got %h want %h", $time, g, e); end end
module port_pin_alternate_override_test;
    timeunit 1ns;
    timeprecision 1ns;
    import port_override_pkg::*;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    apb_addr_t paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    word_t pwdata = '0;
    word_t prdata;
    logic pready;
    logic pslverr;
    logic sleep = 1'b0;
    pin_vec_t ext_irq_enable = '0;
    pin_vec_t port_toggle_override_enable = '0;
    pin_vec_t pad_in, pad_out, pad_oe, pullup_enable;
    pin_vec_t pin_input_to_function, analog_pad_path;
    pin_vec_t ext_drive_en = '0;
    pin_vec_t ext_level = '0;
    int num_errors = 0;
    int tests_run = 0;

    always #50 pclk = ~pclk;

    port_pin_alternate_override port_pin_alternate_override_i (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep(sleep), .ext_irq_enable(ext_irq_enable),
        .port_toggle_override_enable(port_toggle_override_enable),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pullup_enable(pullup_enable),
        .pin_input_to_function(pin_input_to_function),
        .analog_pad_path(analog_pad_path));

    pad_far_side pad_far_side_i (
        .pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pullup_enable(pullup_enable), .ext_drive_en(ext_drive_en),
        .ext_level(ext_level), .pad_in(pad_in));

    task automatic apb(input logic w, input apb_addr_t a, input word_t d,
                       output word_t q, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            $display("[ERR] %0t no answer on the register bus", $time);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input apb_addr_t a, input word_t d);
        word_t q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd(input apb_addr_t a, output word_t q);
        logic e;
        apb(1'b0, a, '0, q, e);
    endtask : rd

    task automatic look(input int n);
        repeat (n) @(negedge pclk);
    endtask : look

    task automatic reset_state;
        word_t q;
        logic e;
        rd(`ADDR_DIR, q); `CHK(q, 32'h0)
        rd(`ADDR_OUT, q); `CHK(q, 32'h0)
        rd(`ADDR_ACFG, q); `CHK(q, 32'h0)
        look(1); `CHK(pad_oe, 2'h0)
        apb(1'b0, 12'h014, '0, q, e); `CHK({e, q}, 33'h100000000)
    endtask : reset_state

    task automatic pullup_table;
        word_t q;
        logic d, o, p;
        for (int i = 0; i < 8; i++) begin
            {d, o, p} = i[2:0];
            wr(`ADDR_DIR, {30'h0, d, d});
            wr(`ADDR_OUT, {30'h0, o, o});
            wr(`ADDR_CTRL, {31'h0, p});
            look(1);
            `CHK(pullup_enable, {2{!d && o && !p}})
            `CHK(pad_oe, {d, d})
            `CHK(pad_out, {2{d && o}})
            rd(`ADDR_CTRL, q); `CHK(q, {31'h0, p})
        end
    endtask : pullup_table

    task automatic toggles;
        word_t q;
        wr(`ADDR_DIR, 32'h0);
        wr(`ADDR_OUT, 32'h0);
        wr(`ADDR_PIN, 32'h1);
        rd(`ADDR_OUT, q); `CHK(q, 32'h1)
        @(posedge pclk);
        port_toggle_override_enable <= 2'h2;
        @(posedge pclk);
        port_toggle_override_enable <= 2'h0;
        rd(`ADDR_OUT, q); `CHK(q, 32'h3)
    endtask : toggles

    task automatic sampling;
        word_t q;
        ext_drive_en <= 2'h3;
        ext_level <= 2'h2;
        look(3);
        rd(`ADDR_PIN, q); `CHK(q, 32'h2)
        `CHK(pin_input_to_function, 2'h2)
        `CHK(analog_pad_path, 2'h2)
    endtask : sampling

    task automatic converter;
        pin_vec_t oe;
        wr(`ADDR_OUT, 32'h3);
        for (int s = 0; s < 4; s++) begin
            oe = (s == 1) ? 2'h2 : (s == 2) ? 2'h1 : 2'h0;
            wr(`ADDR_ACFG, 32'(s) << `ACFG_SEL_LSB);
            look(1);
            `CHK(pad_oe, oe)
            `CHK(pad_out & oe, 2'h0)
        end
        wr(`ADDR_ACFG, 32'h0);
    endtask : converter

    task automatic sleep_clamp;
        ext_level <= 2'h3;
        sleep <= 1'b1;
        look(2); `CHK(pin_input_to_function, 2'h0)
        @(posedge pclk);
        ext_irq_enable <= 2'h1;
        look(2); `CHK(pin_input_to_function, 2'h1)
        @(posedge pclk);
        ext_irq_enable <= 2'h0;
        wr(`ADDR_ACFG, 32'h18);
        look(2); `CHK(pin_input_to_function, 2'h2)
        wr(`ADDR_ACFG, 32'h08);
        look(2); `CHK(pin_input_to_function, 2'h0)
        @(posedge pclk);
        sleep <= 1'b0;
        look(2); `CHK(pin_input_to_function, 2'h3)
        wr(`ADDR_ACFG, 32'h01);
        look(2); `CHK(pin_input_to_function, 2'h2)
        @(posedge pclk);
        ext_drive_en <= 2'h0;
        wr(`ADDR_ACFG, 32'h0);
    endtask : sleep_clamp

    task automatic reset_midrun;
        word_t q;
        wr(`ADDR_CTRL, 32'h0);
        wr(`ADDR_DIR, 32'h0);
        wr(`ADDR_OUT, 32'h3);
        look(1); `CHK(pullup_enable, 2'h3)
        @(posedge pclk);
        presetn <= 1'b0;
        look(1); `CHK(pullup_enable, 2'h0)
        @(posedge pclk);
        presetn <= 1'b1;
        rd(`ADDR_OUT, q); `CHK(q, 32'h0)
    endtask : reset_midrun

    task automatic report_and_stop;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #500000;
        num_errors++;
        report_and_stop();
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        reset_state();
        pullup_table();
        toggles();
        sampling();
        converter();
        sleep_clamp();
        reset_midrun();
        report_and_stop();
    end
endmodule : port_pin_alternate_override_test
